// *** pkg/ccs_params.svh ***
// Offsets, field positions, reset values and timing counts of the CPU clock switch.
// Assumes a 200 MHz pclk and a 32-bit APB register port.
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ********************************************************
// Register map
// ********************************************************
`define CCS_ADDR_W 12
`define CCS_OFS_CTRL 12'h000
`define CCS_OFS_STATUS 12'h004

// ********************************************************
// Clock control register fields
// ********************************************************
`define CCS_BIT_DIV_LO 0
`define CCS_BIT_DIV_HI 2
`define CCS_BIT_CSS 4
`define CCS_BIT_CLS 5
`define CCS_BIT_MCC 7
`define CCS_CTRL_RESET 8'h04
`define CCS_DIV_SLOWEST 3'h4

// ********************************************************
// Status register fields
// ********************************************************
`define CCS_BIT_OSC_ON 0
`define CCS_BIT_STAB_DONE 1
`define CCS_BIT_PENDING 2

// ********************************************************
// Timing
// ********************************************************
`define CCS_PCLK_HZ 200000000
`define CCS_FX_HZ 10000000
`define CCS_FXT_HZ 32768
`define CCS_FX_DIV (`CCS_PCLK_HZ / `CCS_FX_HZ)
`define CCS_SUB_DIV (`CCS_PCLK_HZ / `CCS_FXT_HZ)
`define CCS_STAB_FX_CYCLES 262144
`define CCS_CPU_PER_INSTR 4
`define CCS_MAIN_SWITCH_MAX 16

`endif

// *** pkg/ccs_pkg.sv ***
// Types shared by the CPU clock switch.
// Assumes ccs_params.svh is on the include path.
package ccs_pkg;

  typedef enum logic [1:0] {
    CCS_ST_STAB,
    CCS_ST_RUN,
    CCS_ST_WAIT
  } ccs_state_type;

  typedef struct packed {
    logic main_osc_stop;
    logic clock_source_select;
    logic [2:0] div;
  } ccs_ctrl_type;

  typedef struct packed {
    logic sub;
    logic [2:0] div;
  } ccs_active_type;

endpackage

// *** core/ccs_cpu_clock_switch.sv ***
// CPU clock source and divider switchover with APB control register.
// Assumes pclk at 200 MHz; main and subsystem clocks are modelled as enables.
//
// Function
// R01: On subsystem clock, instruction time fixed at subsystem rate; divider bits ignored.
// R02: Watchdog counting halts while the CPU runs from the subsystem clock.
// R03: Software never issues stop-mode while running from the subsystem clock.
// R04: Divider bits 0-2 and source bit 4 of control select CPU clock.
// R05: After a control write, the old clock runs on for several instructions.
// R06: Read-only bit 5 shows the source truly driving the CPU.
// R07: Delays 16/8/4/2/1 main, 1 leaving subsystem, fx/(4*2^n)/fxt entering it.
// R08: Switchover delay counted in instructions of the pre-switch clock.
// R09: Software never changes divider bits while entering the subsystem clock.
// R10: One write may change divider and return from subsystem to main.
// R11: After reset, main oscillator starts and 2^18 fx cycles pass first.
// R12: After that wait, CPU starts at the slowest main divider.
// R13: Clearing main-oscillator-stop bit 7 restarts main oscillation.
// R14: Software selects subsystem clock only once it oscillates stably.
// R15: After restarting main oscillator, software times stabilization itself.
// R16: Reset loads control with 04h; main oscillator stays off during reset.
// R17: Main-oscillator-stop only takes effect once the CPU runs on subsystem.
// R18: Source status bit changes only when the switchover completes.
// R19: Source switching never truncates a CPU clock phase.
`include "ccs_params.svh"
`timescale 1ns/1ps

module ccs_cpu_clock_switch #(
  parameter int unsigned STAB_FX_CYCLES = `CCS_STAB_FX_CYCLES,
  parameter int unsigned SUB_DIV = `CCS_SUB_DIV
) (
  input wire logic pclk, // APB clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [`CCS_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic cpu_clk_en, // One pulse per CPU clock
  output logic instr_tick, // One pulse per minimum instruction
  output logic cpu_run, // CPU allowed to execute
  output logic wdt_count_en, // Watchdog may count
  output logic main_osc_en, // Main oscillator running
  output logic cpu_on_sub // Active source is subsystem clock
);

  localparam int unsigned FX_DIV = `CCS_FX_DIV;
  localparam logic [4:0] FX_LAST = 5'(FX_DIV - 1);
  localparam logic [12:0] SUB_LAST = 13'(SUB_DIV - 1);
  localparam logic [18:0] STAB_LAST = 19'(STAB_FX_CYCLES - 1);
  // Reset image kept whole so its fields can be selected by position
  localparam logic [7:0] CTRL_RST = `CCS_CTRL_RESET;

  // ********************************************************
  // State
  // ********************************************************
  ccs_pkg::ccs_ctrl_type ctrl_r;
  ccs_pkg::ccs_active_type act_r;
  ccs_pkg::ccs_state_type state_r;
  logic main_osc_en_r;
  logic [3:0] pre_cnt_r;
  logic [1:0] phase_r;
  logic [18:0] stab_cnt_r;
  logic [7:0] wait_cnt_r;
  logic [31:0] prdata_r;
  logic cpu_clk_en_r;
  logic instr_tick_r;

  logic fx_tick;
  logic sub_tick;
  logic main_cpu_tick;
  logic cpu_tick;
  logic instr_end;
  logic apply_now;
  logic change_req;
  logic [3:0] pre_mask;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;

  // ********************************************************
  // Helpers
  // ********************************************************
  // Divider codes above 4 are illegal; they run as the slowest stage.
  function automatic logic [2:0] eff_div(input logic [2:0] d);
    eff_div = (d > `CCS_DIV_SLOWEST) ? `CCS_DIV_SLOWEST : d;
  endfunction

  // Instructions of the old clock to wait before switching
  function automatic logic [7:0] switch_delay(input ccs_pkg::ccs_active_type a,
                                              input logic to_sub);
    int unsigned per_sub;
    per_sub = `CCS_CPU_PER_INSTR * `CCS_FXT_HZ * (32'd1 << a.div);
    if (a.sub) begin
      switch_delay = 8'h01; // R07
    end else if (to_sub) begin
      switch_delay = 8'((`CCS_FX_HZ + per_sub - 1) / per_sub); // R07
    end else begin
      switch_delay = 8'(`CCS_MAIN_SWITCH_MAX >> a.div); // R07
    end
  endfunction

  // ********************************************************
  // APB slave
  // ********************************************************
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_ok = (paddr == `CCS_OFS_CTRL) || (paddr == `CCS_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r.div <= CTRL_RST[`CCS_BIT_DIV_HI:`CCS_BIT_DIV_LO]; // R16
      ctrl_r.clock_source_select <= CTRL_RST[`CCS_BIT_CSS]; // R16
      ctrl_r.main_osc_stop <= CTRL_RST[`CCS_BIT_MCC]; // R16
    end else if (apb_access && pwrite && paddr == `CCS_OFS_CTRL) begin
      ctrl_r.div <= pwdata[`CCS_BIT_DIV_HI:`CCS_BIT_DIV_LO]; // R04
      ctrl_r.clock_source_select <= pwdata[`CCS_BIT_CSS]; // R04
      ctrl_r.main_osc_stop <= pwdata[`CCS_BIT_MCC];
    end
  end

  // Read data is latched in the setup phase so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == `CCS_OFS_CTRL) begin
        prdata_r[`CCS_BIT_DIV_HI:`CCS_BIT_DIV_LO] <= ctrl_r.div;
        prdata_r[`CCS_BIT_CSS] <= ctrl_r.clock_source_select;
        prdata_r[`CCS_BIT_CLS] <= act_r.sub; // R06
        prdata_r[`CCS_BIT_MCC] <= ctrl_r.main_osc_stop;
      end else if (paddr == `CCS_OFS_STATUS) begin
        prdata_r[`CCS_BIT_OSC_ON] <= main_osc_en_r;
        prdata_r[`CCS_BIT_STAB_DONE] <= (state_r != ccs_pkg::CCS_ST_STAB);
        prdata_r[`CCS_BIT_PENDING] <= (state_r == ccs_pkg::CCS_ST_WAIT);
      end
    end
  end

  // ********************************************************
  // Main oscillator
  // ********************************************************
  // Held off in reset; stop request waits until the CPU has left the main clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_en_r <= 1'b0; // R16
    end else begin
      main_osc_en_r <= !(ctrl_r.main_osc_stop && act_r.sub); // R11 R13 R17
    end
  end

  // ********************************************************
  // Source clock enables
  // ********************************************************
  // Both dividers restart at a switch so the first new period is whole.
  ccs_tick_div #(
    .W(5),
    .LAST(FX_LAST)
  ) u_fx_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(main_osc_en_r),
    .restart(apply_now),
    .tick(fx_tick)
  );

  // The subsystem oscillator is never stopped, so its divider always runs.
  ccs_tick_div #(
    .W(13),
    .LAST(SUB_LAST)
  ) u_sub_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .restart(apply_now),
    .tick(sub_tick)
  );

  // ********************************************************
  // CPU clock prescaler
  // ********************************************************
  assign pre_mask = 4'((5'h01 << act_r.div) - 5'h01);
  assign main_cpu_tick = fx_tick && ((pre_cnt_r & pre_mask) == pre_mask);
  // Divider bits are not consulted on the subsystem clock.
  assign cpu_tick = (state_r != ccs_pkg::CCS_ST_STAB)
                    && (act_r.sub ? sub_tick : main_cpu_tick); // R01

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 4'h0;
    end else if (apply_now) begin
      pre_cnt_r <= 4'h0; // R19
    end else if (fx_tick) begin
      pre_cnt_r <= main_cpu_tick ? 4'h0 : pre_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
    end else if (apply_now) begin
      phase_r <= 2'h0;
    end else if (cpu_tick) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign instr_end = cpu_tick && (phase_r == 2'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_r <= 1'b0;
    end else begin
      cpu_clk_en_r <= cpu_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_tick_r <= 1'b0;
    end else begin
      instr_tick_r <= instr_end;
    end
  end

  // ********************************************************
  // Switchover control
  // ********************************************************
  // On the subsystem clock a divider-only change does not switch anything.
  assign change_req = (ctrl_r.clock_source_select != act_r.sub)
                      || (!ctrl_r.clock_source_select && eff_div(ctrl_r.div) != act_r.div); // R01 R04
  // Switch lands on an instruction boundary of the old clock.
  assign apply_now = (state_r == ccs_pkg::CCS_ST_WAIT) && cpu_tick
                     && (phase_r == 2'h3) && (wait_cnt_r == 8'h01); // R05 R08 R19

  // Counts fx ticks only while the CPU is held in the wait after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_r <= 19'h00000;
    end else if (state_r == ccs_pkg::CCS_ST_STAB && fx_tick) begin
      stab_cnt_r <= stab_cnt_r + 19'h00001; // R11
    end
  end

  // Loaded once per request; later writes only re-target the end value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_r <= 8'h00;
    end else if (state_r == ccs_pkg::CCS_ST_RUN && change_req) begin
      wait_cnt_r <= switch_delay(act_r, ctrl_r.clock_source_select); // R07
    end else if (state_r == ccs_pkg::CCS_ST_WAIT && instr_end && !apply_now) begin
      wait_cnt_r <= wait_cnt_r - 8'h01; // R08
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ccs_pkg::CCS_ST_STAB;
    end else begin
      unique case (state_r)
        ccs_pkg::CCS_ST_STAB: begin
          if (fx_tick && stab_cnt_r == STAB_LAST) begin
            state_r <= ccs_pkg::CCS_ST_RUN; // R11
          end
        end
        ccs_pkg::CCS_ST_RUN: begin
          if (change_req) begin
            state_r <= ccs_pkg::CCS_ST_WAIT; // R05
          end
        end
        ccs_pkg::CCS_ST_WAIT: begin
          if (apply_now) begin
            state_r <= ccs_pkg::CCS_ST_RUN;
          end
        end
      endcase
    end
  end

  // Latest written source is taken, and the divider too when main is selected, so divider and return to main may change together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r.sub <= 1'b0;
      act_r.div <= `CCS_DIV_SLOWEST; // R12
    end else if (apply_now) begin
      act_r.sub <= ctrl_r.clock_source_select; // R18
      if (!ctrl_r.clock_source_select) begin
        act_r.div <= eff_div(ctrl_r.div); // R10
      end
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign cpu_clk_en = cpu_clk_en_r;
  assign instr_tick = instr_tick_r;
  assign cpu_run = (state_r != ccs_pkg::CCS_ST_STAB);
  assign wdt_count_en = !act_r.sub; // R02
  assign main_osc_en = main_osc_en_r;
  assign cpu_on_sub = act_r.sub; // R06

endmodule

// ********************************************************
// Free-running tick divider
// ********************************************************
// Restart zeroes the count so the first period after a switch is whole.
module ccs_tick_div #(
  parameter int unsigned W = 5,
  parameter logic [W-1:0] LAST = '1
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Count while high
  input wire logic restart, // Zero the count
  output logic tick // One pulse per period
);

  logic [W-1:0] cnt_r;

  assign tick = run && (cnt_r == LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!run || tick || restart) begin
      cnt_r <= '0; // R19
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

endmodule

// *** bench/ccs_sw_model.sv ***
// Software model: drives the clock switch register port over APB.
// Assumes pready is sampled at rising pclk edges.
`timescale 1ns/1ps

module ccs_sw_model (
  input wire logic pclk, // Bus clock
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Address
  output logic [31:0] pwdata // Write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'hFFFFFFFF;
  end

  // ********
  // Transfers
  // ********
  // Register traffic only; main-oscillator stop requests go out as ordinary control writes
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit ok);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (i = 0; i < 16 && !ok; i++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
      q = prdata;
      e = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** bench/ccs_chk.sv ***
// Port checks of the CPU clock switch.
// Assumes binding into ccs_cpu_clock_switch with its parameters.
`include "ccs_params.svh"
`timescale 1ns/1ps

module ccs_chk #(
  parameter int unsigned STAB_FX_CYCLES = 8,
  parameter int unsigned SUB_DIV = 40
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [`CCS_ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic cpu_clk_en, // CPU clock pulse
  input wire logic instr_tick, // Instruction pulse
  input wire logic cpu_run, // CPU runs
  input wire logic wdt_count_en, // Watchdog enable
  input wire logic main_osc_en, // Main osc on
  input wire logic cpu_on_sub // On subsystem clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned up_cnt, gap_cnt, sub_cnt;
  logic mapped;
  assign mapped = (paddr == `CCS_OFS_CTRL) || (paddr == `CCS_OFS_STATUS);

  // Saturating up_cnt and sub_cnt keep long runs from wrapping; gap_cnt clears on each CPU clock pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 0;
      gap_cnt <= 0;
      sub_cnt <= 0;
    end else begin
      up_cnt <= (up_cnt < 1000000) ? up_cnt + 1 : up_cnt;
      gap_cnt <= cpu_clk_en ? 0 : gap_cnt + 1;
      sub_cnt <= !cpu_on_sub ? 0 : ((sub_cnt < 100000) ? sub_cnt + 1 : sub_cnt);
    end
  end

  // ********
  // Assertions
  // ********
  sequence s_quiet;
    !cpu_clk_en [*8];
  endsequence
  // Status and the last old-clock instruction pulse leave the same edge
  sequence s_tick_seen;
    instr_tick && cpu_clk_en;
  endsequence

  a_wdt_halt: assert property ($stable(cpu_on_sub) |-> wdt_count_en == !cpu_on_sub)
    else $error("watchdog enable wrong for clock source");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_ok_mapped: assert property (psel && penable && mapped |-> pready && !pslverr)
    else $error("mapped access not answered cleanly");
  a_osc_main: assert property (cpu_run && !cpu_on_sub |-> main_osc_en)
    else $error("main oscillator off while on main clock");
  a_stab_wait: assert property ($rose(cpu_run) |->
    up_cnt >= STAB_FX_CYCLES * `CCS_FX_DIV && up_cnt <= STAB_FX_CYCLES * `CCS_FX_DIV + 8)
    else $error("stabilization wait length wrong");
  a_gated_before: assert property (!cpu_run |-> !cpu_clk_en && !instr_tick)
    else $error("CPU clocked before stabilization");
  a_sub_rate: assert property (cpu_on_sub && cpu_clk_en && sub_cnt > 2 * SUB_DIV |->
    gap_cnt == SUB_DIV - 1)
    else $error("subsystem clock rate wrong");
  a_status_tick: assert property ($changed(cpu_on_sub) |-> s_tick_seen)
    else $error("source status moved off an instruction boundary");
  a_clk_no_runt: assert property (cpu_clk_en |=> s_quiet)
    else $error("CPU clock pulses too close");
endmodule

bind ccs_cpu_clock_switch ccs_chk #(
  .STAB_FX_CYCLES(STAB_FX_CYCLES),
  .SUB_DIV(SUB_DIV)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_clk_en(cpu_clk_en),
  .instr_tick(instr_tick), .cpu_run(cpu_run), .wdt_count_en(wdt_count_en),
  .main_osc_en(main_osc_en), .cpu_on_sub(cpu_on_sub)
);

// *** bench/tb.sv ***
// Self-checking bench of the CPU clock switch.
// Assumes the software model on APB and the bound checker.
`timescale 1ns/1ps
`include "ccs_params.svh"
`define CHK(n, x, g) begin \
  compares++; \
  if ((g) !== (x)) begin \
    error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, x, g); \
  end \
end

module tb;
  localparam int SUBD = 40;
  localparam int INS = `CCS_FX_DIV * `CCS_CPU_PER_INSTR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic cpu_clk_en, instr_tick, cpu_run, wdt_count_en, main_osc_en, cpu_on_sub;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int error_cnt = 0;
  int compares = 0;
  int p;

  ccs_cpu_clock_switch #(.STAB_FX_CYCLES(8), .SUB_DIV(SUBD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_clk_en(cpu_clk_en),
    .instr_tick(instr_tick), .cpu_run(cpu_run), .wdt_count_en(wdt_count_en),
    .main_osc_en(main_osc_en), .cpu_on_sub(cpu_on_sub));
  ccs_sw_model sw (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ********
  // Tasks
  // ********
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    bit ok;
    sw.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task meas(output int n);
    int t;
    t = 0;
    while (instr_tick !== 1'b1 && t < 3000) begin
      @(posedge pclk);
      #1;
      t++;
    end
    if (t >= 3000) begin
      error_cnt++;
      print_verdict();
    end
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (instr_tick !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // Old-clock instructions until the new CPU clock period shows
  task sw_switch(input logic [31:0] d, input int n_x, input int per);
    int n, gap, t;
    bit done;
    acc(1'b1, `CCS_OFS_CTRL, d);
    n = 0;
    gap = -100000;
    done = 1'b0;
    for (t = 0; t < 20000 && !done; t++) begin
      @(posedge pclk);
      #1;
      if (instr_tick === 1'b1) n++;
      if (cpu_clk_en === 1'b1) begin
        done = (gap == per - 1);
        gap = 0;
      end else gap++;
    end
    `CHK("new clock", 1'b1, done)
    `CHK("switch delay", 1'b1, n >= n_x - 1 && n <= n_x + 1)
    if (!done) print_verdict();
  endtask

  // ********
  // Tests
  // ********
  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    `CHK("osc in reset", 1'b0, main_osc_en)
    presetn <= 1'b1;
    acc(1'b0, `CCS_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000004, q)
    for (p = 0; p < 400 && cpu_run !== 1'b1; p++) @(posedge pclk);
    `CHK("cpu run", 1'b1, cpu_run)
    if (cpu_run !== 1'b1) print_verdict();
    meas(p);
    `CHK("slow instr", INS << `CCS_DIV_SLOWEST, p)
    acc(1'b0, `CCS_OFS_STATUS, 32'h0);
    `CHK("status run", 32'h00000003, q)
    $display("test reset done");
    sw_switch(32'h00, 1, `CCS_FX_DIV);
    sw_switch(32'h03, 16, `CCS_FX_DIV << 3);
    $display("test divider done");
    sw_switch(32'h13, 10, SUBD);
    acc(1'b0, `CCS_OFS_CTRL, 32'h0);
    `CHK("ctrl on sub", 32'h00000033, q)
    `CHK("wdt on sub", 1'b0, wdt_count_en)
    acc(1'b1, `CCS_OFS_CTRL, 32'h10);
    meas(p);
    `CHK("sub instr", 4 * SUBD, p)
    acc(1'b1, `CCS_OFS_CTRL, 32'h90);
    repeat (3) @(posedge pclk);
    `CHK("osc stopped", 1'b0, main_osc_en)
    acc(1'b1, `CCS_OFS_CTRL, 32'h10);
    repeat (3) @(posedge pclk);
    `CHK("osc restart", 1'b1, main_osc_en)
    repeat (200) @(posedge pclk);
    sw_switch(32'h02, 1, `CCS_FX_DIV << 2);
    acc(1'b0, `CCS_OFS_CTRL, 32'h0);
    `CHK("ctrl on main", 32'h00000002, q)
    $display("test subsystem done");
    acc(1'b1, `CCS_OFS_CTRL, 32'h82);
    repeat (50) @(posedge pclk);
    `CHK("osc kept", 1'b1, main_osc_en)
    acc(1'b1, `CCS_OFS_CTRL, 32'h02);
    acc(1'b0, 12'h008, 32'h0);
    `CHK("unmapped data", 32'h0, q)
    `CHK("unmapped err", 1'b1, e)
    // Illegal divider code runs as the slowest stage
    sw_switch(32'h07, 4, `CCS_FX_DIV << 4);
    acc(1'b1, `CCS_OFS_CTRL, 32'h01);
    acc(1'b0, `CCS_OFS_STATUS, 32'h0);
    `CHK("status pending", 32'h00000007, q)
    $display("test bus done");
    print_verdict();
  end
endmodule
